/* ahp_axis_hold.sv */
// axis homing and position hold controller for four axes
// Behaviour
// - hold off on a stepper with encoder stops hold, stall detect and tracking.
// - hold off on a servo axis opens the loop and stops the regulator.
// - in multi-axis mode hold off puts every axis with an entry into open loop.
// - after reset every axis is open loop with hold disabled.
// - an empty multi-axis entry of hold off keeps that axis's feedback.
// - correction velocity is gain times error, clamped to hold velocity.
// - hold gain accepts 1 to 32000, reset value 1.
// - gain report returns current axis gain, stepper with encoder axes only.
// - home active high makes a high home input the true state.
// - home polarity resets active low unless high is the saved default.
// - polarity commands are refused while encoder homing is selected.
// - an empty multi-axis polarity entry keeps that axis's polarity.
// - home seek drives each selected axis forward at preset velocity.
// - switch mode uses home input only; encoder mode adds index, A, B.
// - on home each axis loads its counter with its own seek value.
// - after loading the axis ramps to a stop at the ramp rate.
// - home is sampled every clock so accuracy tracks search velocity.
// - single-axis home seek without a value loads zero.
// - home seek costs 4 queue entries, +2 feedback, +2 power, +3 settle.
// - encoder home is A high, B low, index high, switch low.
// - hold on enables correction with deadband, gain and velocity.
// - inside the deadband the axis is in position and not corrected.
`timescale 1ns/100ps
`default_nettype none
`include "ahp_consts.svh"

module ahp_axis_hold (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // command port
  input wire logic cmdValid,
  input wire ahp_pkg::ahp_cmd_t cmdOp,
  input wire logic multiMode,
  input wire logic [1:0] curAxis,
  input wire logic [`AHP_NAXES-1:0] cmdEntry,
  input wire logic cmdHasParam,
  input wire logic [`AHP_NAXES*`AHP_POS_W-1:0] cmdArgs,
  // configuration
  input wire logic [`AHP_NAXES-1:0] axisServo,
  input wire logic [`AHP_NAXES-1:0] axisEncoder,
  input wire logic [`AHP_NAXES-1:0] homeHighDefault,
  input wire logic powerAutoMode,
  input wire logic settleTimeSet,
  input wire logic [`AHP_VEL_W-1:0] seekVelocity,
  input wire logic [`AHP_VEL_W-1:0] rampRate,
  // pins
  input wire logic [`AHP_NAXES-1:0] homeSwitchPin,
  input wire logic [`AHP_NAXES-1:0] encAPin,
  input wire logic [`AHP_NAXES-1:0] encBPin,
  input wire logic [`AHP_NAXES-1:0] encIndexPin,
  // motion feedback
  input wire logic [`AHP_NAXES-1:0] stepUp,
  input wire logic [`AHP_NAXES-1:0] stepDown,
  input wire logic [`AHP_NAXES*`AHP_POS_W-1:0] targetPos,
  input wire logic [`AHP_NAXES*`AHP_POS_W-1:0] encCount,
  // axis state
  output logic [`AHP_NAXES-1:0] holdEn,
  output logic [`AHP_NAXES-1:0] loopEn,
  output logic [`AHP_NAXES-1:0] homeHighSel,
  output logic [`AHP_NAXES-1:0] encModeSel,
  output logic [`AHP_NAXES*`AHP_POS_W-1:0] posCount,
  output wire logic [`AHP_NAXES-1:0] homeBusy,
  output wire logic [`AHP_NAXES*`AHP_VEL_W-1:0] seekVelOut,
  output wire logic [`AHP_NAXES*(`AHP_VEL_W+1)-1:0] corrVel,
  output wire logic [`AHP_NAXES-1:0] inPosition,
  // answers
  output logic cmdError,
  output logic reportValid,
  output logic [`AHP_GAIN_W-1:0] reportGain,
  output logic [3:0] queueEntries
);

  localparam int N = `AHP_NAXES;
  localparam int PW = `AHP_POS_W;

  // ==========================================================
  // decoding helpers
  function automatic logic [N-1:0] axisSel(input logic multi, input logic [1:0] cur,
                                           input logic [N-1:0] entry);
    axisSel = multi ? entry : (4'h1 << cur);
  endfunction

  function automatic logic inRange(input logic [PW-1:0] v, input logic [PW-1:0] lo,
                                   input logic [PW-1:0] hi);
    inRange = (v >= lo) && (v <= hi);
  endfunction

  logic [N-1:0] sel;
  logic [PW-1:0] argAx [N];
  logic [N-1:0] reject;
  logic [N-1:0] seekStart;
  logic [`AHP_GAIN_W-1:0] gain [N];
  logic [`AHP_VEL_W-1:0] holdVel [N];
  logic [`AHP_BAND_W-1:0] band [N];
  logic [PW-1:0] homeLoad [N];
  logic [10:0] tickCnt;
  logic tick;
  wire logic [N-1:0] loadHit;
  wire logic [N-1:0] homeTrue;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // empty multi-axis entries leave their axis alone
  assign sel = axisSel(multiMode, curAxis, cmdEntry);

  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      argAx[i] = multiMode ? cmdArgs[i*PW +: PW] : cmdArgs[PW-1:0];
      seekStart[i] = cmdValid && cmdOp == ahp_pkg::CMD_HOME_SEEK && sel[i];
    end
  end

  // ==========================================================
  // pin synchronisers: a change counts once stages two and three agree
  logic [4*N-1:0] pinS1;
  logic [4*N-1:0] pinS2;
  logic [4*N-1:0] pinS3;
  logic [4*N-1:0] pinF;

  always_ff @(posedge clk)
  begin
    pinS1 <= {encIndexPin, encBPin, encAPin, homeSwitchPin};
    pinS2 <= pinS1;
    pinS3 <= pinS2;
  end

  always_ff @(posedge clk)
    if (reset)
      pinF <= '0;
    else
      pinF <= (pinF & (pinS2 ^ pinS3)) | (pinS3 & ~(pinS2 ^ pinS3));

  // ==========================================================
  // update tick for the stopping ramp
  always_ff @(posedge clk)
    if (reset || tickCnt == 11'(`AHP_UPDATE_DIV - 11'h001))
      tickCnt <= 11'h000;
    else
      tickCnt <= tickCnt + 11'h001;

  always_ff @(posedge clk)
    if (reset)
      tick <= 1'b0;
    else
      tick <= tickCnt == 11'(`AHP_UPDATE_DIV - 11'h001);

  // ==========================================================
  // refusals
  always_comb
  begin
    reject = '0;
    for (int i = 0; i < N; i++)
      if (cmdValid && sel[i])
        case (cmdOp)
          ahp_pkg::CMD_HOLD_GAIN:
            reject[i] = !inRange(argAx[i], `AHP_GAIN_MIN, `AHP_GAIN_MAX);
          ahp_pkg::CMD_HOLD_VELOCITY:
            reject[i] = !inRange(argAx[i], `AHP_VEL_MIN, `AHP_VEL_MAX);
          ahp_pkg::CMD_HOLD_DEADBAND:
            reject[i] = !inRange(argAx[i], `AHP_BAND_MIN, `AHP_BAND_MAX);
          ahp_pkg::CMD_HOME_ACTIVE_HIGH, ahp_pkg::CMD_HOME_ACTIVE_LOW:
            reject[i] = encModeSel[i];
          ahp_pkg::CMD_REPORT_HOLD_GAIN:
            reject[i] = multiMode || !axisEncoder[i] || axisServo[i];
          default:
            reject[i] = 1'b0;
        endcase
  end

  // ==========================================================
  // feedback enables
  always_ff @(posedge clk)
    if (reset)
    begin
      holdEn <= '0;
      loopEn <= '0;
    end
    else
      for (int i = 0; i < N; i++)
        if (cmdValid && sel[i])
          case (cmdOp)
            ahp_pkg::CMD_HOLD_OFF:
            begin
              holdEn[i] <= 1'b0;
              loopEn[i] <= 1'b0;
            end
            ahp_pkg::CMD_HOLD_ON:
            begin
              holdEn[i] <= axisEncoder[i] & ~axisServo[i];
              loopEn[i] <= axisServo[i];
            end
            // a home seek cancels stepper hold so correction cannot fight the search
            ahp_pkg::CMD_HOME_SEEK:
              holdEn[i] <= 1'b0;
            default:
              holdEn[i] <= holdEn[i];
          endcase

  // ==========================================================
  // per-axis settings
  always_ff @(posedge clk)
    if (reset)
      for (int i = 0; i < N; i++)
      begin
        gain[i] <= `AHP_GAIN_RESET;
        holdVel[i] <= `AHP_VEL_RESET;
        band[i] <= `AHP_BAND_RESET;
      end
    else
      for (int i = 0; i < N; i++)
        if (cmdValid && sel[i] && !reject[i])
          case (cmdOp)
            ahp_pkg::CMD_HOLD_GAIN:
              gain[i] <= argAx[i][`AHP_GAIN_W-1:0];
            ahp_pkg::CMD_HOLD_VELOCITY:
              holdVel[i] <= argAx[i][`AHP_VEL_W-1:0];
            ahp_pkg::CMD_HOLD_DEADBAND:
              band[i] <= argAx[i][`AHP_BAND_W-1:0];
            default:
              gain[i] <= gain[i];
          endcase

  // the saved power-up polarity is caught by the clocked reset
  always_ff @(posedge clk)
    if (reset)
    begin
      homeHighSel <= homeHighDefault;
      encModeSel <= '0;
    end
    else
      for (int i = 0; i < N; i++)
        if (cmdValid && sel[i] && !reject[i])
          case (cmdOp)
            ahp_pkg::CMD_HOME_ACTIVE_HIGH:
              homeHighSel[i] <= 1'b1;
            ahp_pkg::CMD_HOME_ACTIVE_LOW:
              homeHighSel[i] <= 1'b0;
            ahp_pkg::CMD_HOME_SWITCH_MODE:
              encModeSel[i] <= 1'b0;
            ahp_pkg::CMD_HOME_ENCODER_MODE:
              encModeSel[i] <= 1'b1;
            default:
              encModeSel[i] <= encModeSel[i];
          endcase

  // ==========================================================
  // answers
  always_ff @(posedge clk)
    if (reset)
    begin
      cmdError <= 1'b0;
      reportValid <= 1'b0;
      reportGain <= `AHP_GAIN_RESET;
      queueEntries <= 4'h0;
    end
    else
    begin
      cmdError <= |reject;
      reportValid <= cmdValid && cmdOp == ahp_pkg::CMD_REPORT_HOLD_GAIN && ~|reject;
      if (cmdValid && cmdOp == ahp_pkg::CMD_REPORT_HOLD_GAIN)
        reportGain <= gain[curAxis];
      if (|seekStart)
        queueEntries <= `AHP_Q_HOME_BASE
          + (|(sel & (axisEncoder | axisServo)) ? `AHP_Q_FEEDBACK : 4'h0)
          + (powerAutoMode ? `AHP_Q_POWER_AUTO : 4'h0)
          + (settleTimeSet ? `AHP_Q_SETTLE : 4'h0);
    end

  // ==========================================================
  // homing: load values and position counters
  always_ff @(posedge clk)
    if (reset)
      for (int i = 0; i < N; i++)
        homeLoad[i] <= `AHP_POS_RESET;
    else
      for (int i = 0; i < N; i++)
        if (seekStart[i] && !homeBusy[i])
          homeLoad[i] <= (!multiMode && !cmdHasParam) ? `AHP_POS_RESET : argAx[i];

  always_ff @(posedge clk)
    if (reset)
      posCount <= '0;
    else
      for (int i = 0; i < N; i++)
        if (loadHit[i])
          posCount[i*PW +: PW] <= homeLoad[i];
        else if (stepUp[i] && !stepDown[i])
          posCount[i*PW +: PW] <= posCount[i*PW +: PW] + 24'h000001;
        else if (stepDown[i] && !stepUp[i])
          posCount[i*PW +: PW] <= posCount[i*PW +: PW] - 24'h000001;

  for (genvar i = 0; i < N; i++)
  begin : gAxis
    logic sw;
    ahp_home_if hsIf();

    assign sw = pinF[i];
    // polled every clock: error grows only with steps per clock
    assign homeTrue[i] = encModeSel[i]
      ? (pinF[N+i] & ~pinF[2*N+i] & pinF[3*N+i] & ~sw)
      : (homeHighSel[i] ? sw : ~sw);

    assign hsIf.start = seekStart[i];
    assign hsIf.tick = tick;
    assign hsIf.homeHit = homeTrue[i];
    assign hsIf.seekVel = seekVelocity;
    assign hsIf.rampRate = rampRate;
    assign loadHit[i] = hsIf.loadPulse;
    assign homeBusy[i] = hsIf.busy;
    assign seekVelOut[i*`AHP_VEL_W +: `AHP_VEL_W] = hsIf.vel;

    ahp_home_seek uSeek (
      .clk(clk),
      .reset(reset),
      .hs(hsIf.seek)
    );

    ahp_hold_corr uCorr (
      .clk(clk),
      .reset(reset),
      .enable(holdEn[i]),
      .gain(gain[i]),
      .velMax(holdVel[i]),
      .band(band[i]),
      .err(targetPos[i*PW +: PW] - encCount[i*PW +: PW]),
      .vel(corrVel[i*(`AHP_VEL_W+1) +: `AHP_VEL_W+1]),
      .inPosition(inPosition[i])
    );

    chk_gain_range:
      assert property (gain[i] >= `AHP_GAIN_RESET && gain[i] <= 15'h7d00)
      else $error("hold gain out of range");

    chk_polarity_enc:
      assert property (cmdValid && sel[i] && encModeSel[i]
                       && (cmdOp == ahp_pkg::CMD_HOME_ACTIVE_HIGH
                       || cmdOp == ahp_pkg::CMD_HOME_ACTIVE_LOW)
                       |=> $stable(homeHighSel[i]) && cmdError)
      else $error("polarity changed in encoder homing");

    chk_home_load:
      assert property (loadHit[i] |=> posCount[i*PW +: PW] == $past(homeLoad[i]))
      else $error("counter not loaded with home value");

    chk_seek_start:
      assert property (seekStart[i] && !homeBusy[i]
                       |=> homeBusy[i] && hsIf.vel == $past(seekVelocity))
      else $error("seek did not start at preset velocity");
  end

  // ==========================================================
  // checks
  chk_reset_open:
    assert property ($fell(reset) |-> holdEn == '0 && loopEn == '0)
    else $error("axis not open loop after reset");

  chk_holdoff_clear:
    assert property (cmdValid && cmdOp == ahp_pkg::CMD_HOLD_OFF
                     |=> ((holdEn | loopEn) & $past(sel)) == '0)
    else $error("hold off left feedback on");

  chk_holdoff_keep:
    assert property (cmdValid && cmdOp == ahp_pkg::CMD_HOLD_OFF
                     |=> ((holdEn ^ $past(holdEn)) & ~$past(sel)) == '0)
    else $error("hold off touched an empty entry");

  chk_queue_cost:
    assert property (cmdValid && cmdOp == ahp_pkg::CMD_HOME_SEEK && |sel
                     && powerAutoMode && settleTimeSet && ~|(sel & (axisEncoder | axisServo))
                     |=> queueEntries == 4'h9)
    else $error("wrong home seek queue cost");

endmodule

`default_nettype wire

/* ahp_consts.svh */
// numeric constants of the axis homing and position hold block
`ifndef AHP_CONSTS_SVH
`define AHP_CONSTS_SVH

// widths
`define AHP_NAXES 4
`define AHP_POS_W 24
`define AHP_VEL_W 20
`define AHP_GAIN_W 15
`define AHP_BAND_W 16

// accepted parameter ranges, compared against 24-bit command arguments
`define AHP_GAIN_MIN 24'h000001
`define AHP_GAIN_MAX 24'h007d00
`define AHP_VEL_MIN 24'h000001
`define AHP_VEL_MAX 24'h0fde7f
`define AHP_BAND_MIN 24'h000000
`define AHP_BAND_MAX 24'h00fa00

// reset values
`define AHP_GAIN_RESET 15'h0001
`define AHP_VEL_RESET 20'h00000
`define AHP_BAND_RESET 16'h0000
`define AHP_POS_RESET 24'h000000

// command queue cost of a home seek
`define AHP_Q_HOME_BASE 4'h4
`define AHP_Q_FEEDBACK 4'h2
`define AHP_Q_POWER_AUTO 4'h2
`define AHP_Q_SETTLE 4'h3

// clock cycles per update tick (200 MHz / 2000 = 100 kHz)
`define AHP_UPDATE_DIV 11'h7d0

`endif

/* ahp_pkg.sv */
// types of the axis homing and position hold block
`default_nettype none

package ahp_pkg;

  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_HOLD_OFF = 4'h1,
    CMD_HOLD_ON = 4'h2,
    CMD_HOLD_GAIN = 4'h3,
    CMD_REPORT_HOLD_GAIN = 4'h4,
    CMD_HOME_ACTIVE_HIGH = 4'h5,
    CMD_HOME_ACTIVE_LOW = 4'h6,
    CMD_HOME_SEEK = 4'h7,
    CMD_HOME_SWITCH_MODE = 4'h8,
    CMD_HOME_ENCODER_MODE = 4'h9,
    CMD_HOLD_VELOCITY = 4'ha,
    CMD_HOLD_DEADBAND = 4'hb
  } ahp_cmd_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_SEEK = 2'b01,
    HS_STOP = 2'b11
  } ahp_home_state_t;

endpackage

`default_nettype wire

/* ahp_home_if.sv */
// carrier between the axis controller and one homing sequencer
`timescale 1ns/100ps
`default_nettype none
`include "ahp_consts.svh"

interface ahp_home_if;
  logic start;
  logic tick;
  logic homeHit;
  logic [`AHP_VEL_W-1:0] seekVel;
  logic [`AHP_VEL_W-1:0] rampRate;
  logic loadPulse;
  logic busy;
  logic [`AHP_VEL_W-1:0] vel;

  modport ctl (
    output start, tick, homeHit, seekVel, rampRate,
    input loadPulse, busy, vel
  );

  modport seek (
    input start, tick, homeHit, seekVel, rampRate,
    output loadPulse, busy, vel
  );
endinterface

`default_nettype wire

/* ahp_home_seek.sv */
// homing sequencer of one axis: seek forward, load on home, ramp down
`timescale 1ns/100ps
`default_nettype none
`include "ahp_consts.svh"

module ahp_home_seek (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // sequencer side of the carrier
  ahp_home_if.seek hs
);

  ahp_pkg::ahp_home_state_t state;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ==========================================================
  // sequencer
  always_ff @(posedge clk)
    if (reset)
    begin
      state <= ahp_pkg::HS_IDLE;
      hs.vel <= `AHP_VEL_RESET;
      hs.loadPulse <= 1'b0;
      hs.busy <= 1'b0;
    end
    else
    begin
      hs.loadPulse <= 1'b0;
      case (state)
        ahp_pkg::HS_IDLE:
          if (hs.start)
          begin
            state <= ahp_pkg::HS_SEEK;
            hs.vel <= hs.seekVel;
            hs.busy <= 1'b1;
          end
        ahp_pkg::HS_SEEK:
          if (hs.homeHit)
          begin
            state <= ahp_pkg::HS_STOP;
            hs.loadPulse <= 1'b1;
          end
        ahp_pkg::HS_STOP:
          // stops past the home point; the user must allow that distance
          if (hs.tick)
          begin
            if (hs.vel > hs.rampRate)
              hs.vel <= hs.vel - hs.rampRate;
            else
            begin
              hs.vel <= `AHP_VEL_RESET;
              state <= ahp_pkg::HS_IDLE;
              hs.busy <= 1'b0;
            end
          end
        default:
        begin
          state <= ahp_pkg::HS_IDLE;
          hs.vel <= `AHP_VEL_RESET;
          hs.busy <= 1'b0;
        end
      endcase
    end

  // ==========================================================
  // checks
  sequence homeFound;
    state == ahp_pkg::HS_SEEK && hs.homeHit;
  endsequence

  sequence lastRampStep;
    state == ahp_pkg::HS_STOP && hs.tick && hs.vel <= hs.rampRate;
  endsequence

  chk_detect_load:
    assert property (homeFound |=> hs.loadPulse && state == ahp_pkg::HS_STOP)
    else $error("home detect did not load the counter");

  chk_ramp_stop:
    assert property (lastRampStep |=> hs.vel == `AHP_VEL_RESET && !hs.busy)
    else $error("ramp did not end at standstill");

endmodule

`default_nettype wire

/* ahp_hold_corr.sv */
// position correction of one axis: gain times error, clamped, with deadband
`timescale 1ns/100ps
`default_nettype none
`include "ahp_consts.svh"

module ahp_hold_corr (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // settings
  input wire logic enable,
  input wire logic [`AHP_GAIN_W-1:0] gain,
  input wire logic [`AHP_VEL_W-1:0] velMax,
  input wire logic [`AHP_BAND_W-1:0] band,
  // error, target minus encoder count
  input wire logic signed [`AHP_POS_W-1:0] err,
  // result
  output logic signed [`AHP_VEL_W:0] vel,
  output logic inPosition
);

  logic [`AHP_POS_W-1:0] mag;
  logic [38:0] prod;
  logic [`AHP_VEL_W-1:0] clamped;
  logic inBand;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  always_comb
  begin
    mag = err[`AHP_POS_W-1] ? `AHP_POS_W'(-err) : `AHP_POS_W'(err);
    prod = mag * gain;
    clamped = (prod > {19'h00000, velMax}) ? velMax : prod[`AHP_VEL_W-1:0];
    inBand = mag <= {8'h00, band};
  end

  always_ff @(posedge clk)
    if (reset || !enable || inBand)
    begin
      vel <= '0;
      inPosition <= enable && !reset;
    end
    else
    begin
      vel <= err[`AHP_POS_W-1] ? -$signed({1'b0, clamped}) : $signed({1'b0, clamped});
      inPosition <= 1'b0;
    end

  chk_corr_clamp:
    assert property (enable && !inBand |=> vel <= $signed({1'b0, $past(velMax)})
                     && vel >= -$signed({1'b0, $past(velMax)}))
    else $error("correction velocity above hold velocity");

  chk_deadband_rest:
    assert property (enable && inBand |=> vel == 0 && inPosition)
    else $error("correction applied inside deadband");

endmodule

`default_nettype wire

/* ahp_motor_model.sv */
// behavioural model of four motors with encoders and home switches
`timescale 1ns/100ps
`default_nettype none
`include "ahp_consts.svh"

module ahp_motor_model #(
  parameter int HOME_AT = 40
) (
  // clock
  input wire logic clk,
  // drive commands from the controller
  input wire logic [3:0] busy,
  input wire logic [79:0] vel,
  input wire logic [3:0] highSel,
  input wire logic [3:0] encSel,
  // pins
  output logic [3:0] sw,
  output logic [3:0] encA,
  output logic [3:0] encB,
  output logic [3:0] index
);
  int pos [4] = '{default: 0};
  logic [3:0] at;

  // ==========================================
  // motion: forward only, one count per clock
  // a stopped motor is set back before home, so a later seek never starts on home
  always @(posedge clk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (!busy[i])
        pos[i] <= 0;
      else if (vel[i*20 +: 20] != 20'h00000)
        pos[i] <= pos[i] + 1;
    end
  end

  // switch is inactive before the home point, so a seek must really travel
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      at[i] = pos[i] >= HOME_AT;
      sw[i] = encSel[i] ? !at[i] : (at[i] ~^ highSel[i]);
      encA[i] = at[i];
      encB[i] = !at[i];
      index[i] = at[i];
    end
  end
endmodule

`default_nettype wire

/* ahp_axis_hold_tb.sv */
// self-checking bench of the axis homing and position hold block
`timescale 1ns/100ps
`default_nettype none
`include "ahp_consts.svh"

module ahp_axis_hold_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cmdValid = 1'b0;
  ahp_pkg::ahp_cmd_t cmdOp = ahp_pkg::CMD_NONE;
  logic multiMode = 1'b0;
  logic [1:0] curAxis = 2'h0;
  logic [3:0] cmdEntry = 4'h0;
  logic cmdHasParam = 1'b0;
  logic [95:0] cmdArgs = 96'h0;
  logic powerAutoMode = 1'b0;
  logic settleTimeSet = 1'b0;
  logic [95:0] targetPos = 96'h0;
  logic [95:0] encCount = 96'h0;
  logic [3:0] stepUp = 4'h0;
  logic [3:0] stepDown = 4'h0;
  logic [3:0] sw, encA, encB, index, holdEn, loopEn, homeHighSel, encModeSel, homeBusy, inPos;
  logic [95:0] posCount;
  logic [79:0] seekVelOut;
  logic [83:0] corrVel;
  logic cmdError, reportValid, lastErr, lastRep;
  logic [14:0] reportGain;
  logic [3:0] queueEntries;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;

  always #2.5 clk = ~clk;

  ahp_axis_hold i_ahp_axis_hold (.clk(clk), .reset(reset), .cmdValid(cmdValid),
    .cmdOp(cmdOp), .multiMode(multiMode), .curAxis(curAxis), .cmdEntry(cmdEntry),
    .cmdHasParam(cmdHasParam), .cmdArgs(cmdArgs), .axisServo(4'h2), .axisEncoder(4'h1),
    .homeHighDefault(4'h5), .powerAutoMode(powerAutoMode), .settleTimeSet(settleTimeSet),
    .seekVelocity(20'h0000a), .rampRate(20'h00014), .homeSwitchPin(sw),
    .encAPin(encA), .encBPin(encB), .encIndexPin(index), .stepUp(stepUp), .stepDown(stepDown),
    .targetPos(targetPos), .encCount(encCount), .holdEn(holdEn), .loopEn(loopEn),
    .homeHighSel(homeHighSel), .encModeSel(encModeSel), .posCount(posCount),
    .homeBusy(homeBusy), .seekVelOut(seekVelOut), .corrVel(corrVel), .inPosition(inPos),
    .cmdError(cmdError), .reportValid(reportValid), .reportGain(reportGain),
    .queueEntries(queueEntries));

  ahp_motor_model i_ahp_motor_model (.clk(clk), .busy(homeBusy), .vel(seekVelOut),
    .highSel(homeHighSel), .encSel(encModeSel), .sw(sw), .encA(encA), .encB(encB),
    .index(index));

  // ==========================================
  // shared tasks
  task automatic stop_test();
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle command; pulses of the answer are caught in the cycle they stand
  task automatic cmd(input ahp_pkg::ahp_cmd_t op, input logic mm, input logic [1:0] ax,
    input logic [3:0] ent, input logic [95:0] args);
    @(posedge clk);
    #1;
    cmdValid = 1'b1;
    cmdOp = op;
    {multiMode, curAxis, cmdEntry, cmdArgs} = {mm, ax, ent, args};
    @(posedge clk);
    #1;
    cmdValid = 1'b0;
    lastErr = cmdError;
    lastRep = reportValid;
  endtask

  task automatic set_err(input logic [23:0] t, input logic [23:0] exp);
    targetPos[23:0] = t;
    repeat (4) @(posedge clk);
    #1;
    check({3'h0, corrVel[20:0]}, exp);
  endtask

  task automatic wait_idle();
    for (int n = 0; n < 8000 && homeBusy !== 4'h0; n++)
      #5;
    check({20'h0, homeBusy}, 24'h0);
    check({4'h0, seekVelOut[19:0] | seekVelOut[59:40]}, 24'h0);
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset();
    check({16'h0, holdEn, loopEn}, 24'h0);
    check({20'h0, homeHighSel}, 24'h5);
    check({9'h0, reportGain}, 24'h1);
  endtask

  task automatic t_hold();
    cmd(ahp_pkg::CMD_HOLD_ON, 1'b1, 2'h0, 4'hf, 96'h0);
    check({16'h0, holdEn, loopEn}, 24'h12);
    cmd(ahp_pkg::CMD_HOLD_OFF, 1'b1, 2'h0, 4'h1, 96'h0);
    check({16'h0, holdEn, loopEn}, 24'h02);
    cmd(ahp_pkg::CMD_HOLD_ON, 1'b1, 2'h0, 4'hf, 96'h0);
    cmd(ahp_pkg::CMD_HOLD_OFF, 1'b0, 2'h1, 4'h0, 96'h0);
    check({16'h0, holdEn, loopEn}, 24'h10);
    cmd(ahp_pkg::CMD_HOLD_OFF, 1'b1, 2'h0, 4'hf, 96'h0);
    check({16'h0, holdEn, loopEn}, 24'h0);
  endtask

  task automatic t_gain();
    cmd(ahp_pkg::CMD_HOLD_GAIN, 1'b0, 2'h0, 4'h0, 96'h007d00);
    cmd(ahp_pkg::CMD_HOLD_GAIN, 1'b0, 2'h0, 4'h0, 96'h007d01);
    check({23'h0, lastErr}, 24'h1);
    cmd(ahp_pkg::CMD_HOLD_GAIN, 1'b0, 2'h0, 4'h0, 96'h0);
    check({23'h0, lastErr}, 24'h1);
    cmd(ahp_pkg::CMD_HOLD_GAIN, 1'b0, 2'h2, 4'h0, 96'h5);
    cmd(ahp_pkg::CMD_REPORT_HOLD_GAIN, 1'b0, 2'h0, 4'h0, 96'h0);
    check({8'h0, lastRep, reportGain}, 24'h8000 | 24'h7d00);
    cmd(ahp_pkg::CMD_REPORT_HOLD_GAIN, 1'b0, 2'h1, 4'h0, 96'h0);
    check({23'h0, lastErr}, 24'h1);
  endtask

  task automatic t_pol();
    cmd(ahp_pkg::CMD_HOME_ACTIVE_HIGH, 1'b1, 2'h0, 4'h2, 96'h0);
    check({20'h0, homeHighSel}, 24'h7);
    cmd(ahp_pkg::CMD_HOME_ACTIVE_LOW, 1'b0, 2'h2, 4'h0, 96'h0);
    check({20'h0, homeHighSel}, 24'h3);
    cmd(ahp_pkg::CMD_HOME_ENCODER_MODE, 1'b0, 2'h0, 4'h0, 96'h0);
    check({20'h0, encModeSel}, 24'h1);
    cmd(ahp_pkg::CMD_HOME_ACTIVE_HIGH, 1'b0, 2'h0, 4'h0, 96'h0);
    check({19'h0, lastErr, homeHighSel}, 24'h13);
  endtask

  task automatic t_corr();
    cmd(ahp_pkg::CMD_HOLD_GAIN, 1'b0, 2'h0, 4'h0, 96'h3);
    cmd(ahp_pkg::CMD_HOLD_VELOCITY, 1'b0, 2'h0, 4'h0, 96'h64);
    cmd(ahp_pkg::CMD_HOLD_DEADBAND, 1'b0, 2'h0, 4'h0, 96'h2);
    cmd(ahp_pkg::CMD_HOLD_ON, 1'b0, 2'h0, 4'h0, 96'h0);
    set_err(24'h00000a, 24'h00001e);
    set_err(24'h000032, 24'h000064);
    set_err(24'hfffff6, 24'h1fffe2);
    encCount[23:0] = 24'h000008;
    set_err(24'h00000a, 24'h0);
    check({23'h0, inPos[0]}, 24'h1);
  endtask

  task automatic t_home();
    powerAutoMode = 1'b1;
    settleTimeSet = 1'b1;
    cmd(ahp_pkg::CMD_HOME_SEEK, 1'b1, 2'h0, 4'h5, {24'h0, 24'h456, 24'h0, 24'h123});
    check({20'h0, queueEntries}, 24'hb);
    check({4'h0, seekVelOut[59:40]}, 24'h00000a);
    wait_idle();
    check(posCount[23:0], 24'h000123);
    check(posCount[71:48], 24'h000456);
    stepUp = 4'h1;
    @(posedge clk);
    #1;
    {stepUp, stepDown} = 8'h01;
    check(posCount[23:0], 24'h000124);
    @(posedge clk);
    #1;
    stepDown = 4'h0;
    check(posCount[23:0], 24'h000123);
    cmdHasParam = 1'b1;
    cmd(ahp_pkg::CMD_HOME_SEEK, 1'b0, 2'h2, 4'h0, 96'h321);
    check({20'h0, queueEntries}, 24'h9);
    wait_idle();
    check(posCount[71:48], 24'h000321);
    powerAutoMode = 1'b0;
    settleTimeSet = 1'b0;
    cmdHasParam = 1'b0;
    cmd(ahp_pkg::CMD_HOME_SEEK, 1'b0, 2'h2, 4'h0, 96'h777);
    check({20'h0, queueEntries}, 24'h4);
    wait_idle();
    check(posCount[71:48], 24'h0);
    cmd(ahp_pkg::CMD_HOME_SWITCH_MODE, 1'b0, 2'h0, 4'h0, 96'h0);
    check({20'h0, encModeSel}, 24'h0);
  endtask

  // ==========================================
  // run and timeout
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      error_cnt = error_cnt + 1;
      stop_test();
    end
  end

  initial
  begin
    repeat (20) @(posedge clk);
    #1;
    reset = 1'b0;
    t_reset();
    t_hold();
    t_gain();
    t_pol();
    t_corr();
    t_home();
    stop_test();
  end
endmodule

`default_nettype wire
